/* File: rtl/afb_flag_bus.sv */
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
// What this block does
// - latch flag mode at master reset, high polled
// - direct: strobe selects addressed word onto bus
// - polled: words load in order from one
// - single device wraps to word one fifth
// - sync high only while word one shown
// - latch fall-through select at master reset
// - accept token from previous device input
// - pulse token out with fourth word
// - top address bits match id, rest queue
module afb_flag_bus
  import afb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AFB_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flag_bus_mode_select_i,
  input wire logic fall_through_select_i,
  input wire logic [AFB_ID_W-1:0] device_identity_inputs_i,
  input wire logic almost_full_bus_strobe_i,
  input wire logic [AFB_ADDR_W-1:0] write_queue_address_i,
  input wire logic serial_enable_output_i,
  input wire logic almost_full_token_in_i,
  input wire logic [AFB_QUEUES-1:0] queue_status_i,
  output logic [AFB_WORD_W-1:0] almost_full_flag_bus_o,
  output logic almost_full_flag_bus_oe_o,
  output logic almost_full_bus_sync_o,
  output logic almost_full_token_out_o,
  output logic fall_through_mode_o
);

  // ==========================================================================
  // strap pins
  afb_strap_s strap_pin;
  afb_strap_s strap_sync;
  afb_strap_s strap;
  logic master_reset;

  assign strap_pin.polled = flag_bus_mode_select_i;
  assign strap_pin.fall_through = fall_through_select_i;
  assign strap_pin.id = device_identity_inputs_i;

  afb_sync #(
    .W(AFB_STRAP_W)
  ) u_strap_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(strap_pin),
    .q_o(strap_sync)
  );

  // straps follow the pins only while master reset is held
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap <= '0;
    end
    else if (master_reset)
    begin
      strap <= strap_sync;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fall_through_mode_o <= 1'b0;
    end
    else
    begin
      fall_through_mode_o <= strap.fall_through;
    end
  end

  // ==========================================================================
  // apb slave, one wait state
  logic apb_access;
  logic apb_commit;
  logic [31:0] stat_word;
  afb_poll_e poll_state;
  logic [AFB_IDX_W-1:0] word_idx;

  assign apb_access = psel && penable && !pready;
  assign apb_commit = psel && penable && pready;

  always_comb
  begin
    stat_word = '0;
    stat_word[AFB_STAT_POLLED_BIT] = strap.polled;
    stat_word[AFB_STAT_FALL_THROUGH_SELECT_BIT] = strap.fall_through;
    stat_word[AFB_STAT_TOKEN_BIT] = (poll_state == AFB_HOLD);
    stat_word[AFB_STAT_DRIVE_BIT] = almost_full_flag_bus_oe_o;
    stat_word[AFB_STAT_IDX_LSB +: AFB_IDX_W] = word_idx;
    stat_word[AFB_STAT_ID_LSB +: AFB_ID_W] = strap.id;
    stat_word[AFB_STAT_MRST_BIT] = master_reset;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (apb_access)
    begin
      pready <= 1'b1;
      pslverr <= !(paddr == AFB_CTRL_OFF || paddr == AFB_STAT_OFF);
      if (pwrite)
      begin
        prdata <= '0;
      end
      else if (paddr == AFB_CTRL_OFF)
      begin
        prdata <= {31'h0, master_reset};
      end
      else if (paddr == AFB_STAT_OFF)
      begin
        prdata <= stat_word;
      end
      else
      begin
        prdata <= '0;
      end
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      master_reset <= AFB_CTRL_MRST_RST;
    end
    else if (apb_commit && pwrite && paddr == AFB_CTRL_OFF)
    begin
      master_reset <= pwdata[AFB_CTRL_MRST_BIT];
    end
  end

  // ==========================================================================
  // flag bus control
  logic id_match;
  logic strobe_ok;
  logic poll_load;
  logic [AFB_IDX_W-1:0] direct_idx;

  assign id_match = write_queue_address_i[AFB_ADDR_W-1:AFB_ID_LSB] == strap.id;
  // strobe ignored until serial programming is done
  assign strobe_ok = almost_full_bus_strobe_i && !serial_enable_output_i;
  // token from the chain or one already held
  assign poll_load = (poll_state == AFB_HOLD) || almost_full_token_in_i;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      poll_state <= AFB_WAIT;
      word_idx <= AFB_FIRST_WORD;
    end
    else if (master_reset)
    begin
      poll_state <= (strap_sync.polled && strap_sync.id == AFB_MASTER_ID) ? AFB_HOLD : AFB_WAIT;
      word_idx <= AFB_FIRST_WORD;
    end
    else if (strap.polled && poll_load)
    begin
      word_idx <= word_idx + 2'h1;
      poll_state <= (word_idx == AFB_LAST_WORD) ? AFB_WAIT : AFB_HOLD;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      direct_idx <= AFB_FIRST_WORD;
    end
    else if (master_reset)
    begin
      direct_idx <= AFB_FIRST_WORD;
    end
    else if (!strap.polled && strobe_ok && id_match)
    begin
      direct_idx <= write_queue_address_i[AFB_WSEL_LSB +: AFB_IDX_W];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      almost_full_flag_bus_o <= '0;
      almost_full_flag_bus_oe_o <= 1'b0;
      almost_full_bus_sync_o <= 1'b0;
      almost_full_token_out_o <= 1'b0;
    end
    else if (master_reset)
    begin
      almost_full_flag_bus_oe_o <= 1'b0;
      almost_full_bus_sync_o <= 1'b0;
      almost_full_token_out_o <= 1'b0;
    end
    else if (strap.polled)
    begin
      almost_full_flag_bus_oe_o <= poll_load;
      almost_full_bus_sync_o <= poll_load && word_idx == AFB_FIRST_WORD;
      almost_full_token_out_o <= poll_load && word_idx == AFB_LAST_WORD;
      if (poll_load)
      begin
        almost_full_flag_bus_o <= afb_word(queue_status_i, word_idx);
      end
    end
    else
    begin
      almost_full_bus_sync_o <= 1'b0;
      almost_full_token_out_o <= 1'b0;
      if (strobe_ok)
      begin
        almost_full_flag_bus_oe_o <= id_match;
      end
      if (strobe_ok && id_match)
      begin
        almost_full_flag_bus_o <= afb_word(queue_status_i,
          write_queue_address_i[AFB_WSEL_LSB +: AFB_IDX_W]);
      end
      else
      begin
        // selected word keeps tracking live status
        almost_full_flag_bus_o <= afb_word(queue_status_i, direct_idx);
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic run;
  assign run = !master_reset;

  sequence s_word_one;
    run && strap.polled && almost_full_bus_sync_o;
  endsequence

  sequence s_direct_pick;
    run && !strap.polled && strobe_ok && id_match;
  endsequence

  mode_latch_a: assert property (master_reset |=> strap.polled == $past(strap_sync.polled))
    else $error("flag mode not latched during master reset");

  mode_hold_a: assert property (run && $past(run) |-> $stable(strap))
    else $error("straps changed outside master reset");

  fall_through_select_out_a: assert property (##1 fall_through_mode_o == $past(strap.fall_through))
    else $error("fall-through output does not follow latched select");

  direct_sel_a: assert property (s_direct_pick |=> almost_full_flag_bus_oe_o &&
    almost_full_flag_bus_o == afb_word($past(queue_status_i),
    $past(write_queue_address_i[AFB_WSEL_LSB +: AFB_IDX_W])))
    else $error("direct strobe did not place addressed word");

  id_miss_a: assert property (run && !strap.polled && strobe_ok && !id_match
    |=> !almost_full_flag_bus_oe_o)
    else $error("bus driven for another device id");

  word_one_a: assert property (s_word_one |-> almost_full_flag_bus_o ==
    afb_word($past(queue_status_i), AFB_FIRST_WORD))
    else $error("sync high without word one on bus");

  word_order_a: assert property (s_word_one ##1 run [*3] |->
    almost_full_flag_bus_oe_o && almost_full_token_out_o && !almost_full_bus_sync_o)
    else $error("words not loaded in order up to fourth");

  // token back right after the fourth word restarts word one
  poll_wrap_a: assert property (s_word_one ##1 run [*2] ##1
    (run && almost_full_token_in_i) |=> almost_full_bus_sync_o)
    else $error("single device did not wrap to word one");

  token_take_a: assert property (run && strap.polled && poll_state == AFB_WAIT &&
    almost_full_token_in_i ##1 run |-> almost_full_bus_sync_o)
    else $error("token in did not start word one");

  token_pulse_a: assert property (run && almost_full_token_out_o ##1 run
    |-> !almost_full_token_out_o)
    else $error("token out longer than one cycle");

  idle_quiet_a: assert property (run && strap.polled && poll_state == AFB_WAIT &&
    !almost_full_token_in_i |=> !almost_full_bus_sync_o && !almost_full_flag_bus_oe_o &&
    $stable(word_idx))
    else $error("idle device drove sync or advanced");

endmodule

/* File: rtl/afb_pkg.sv */
package afb_pkg;

  // ==========================================================================
  // geometry
  localparam int AFB_ADDR_W = 8;
  localparam int AFB_ID_W = 3;
  localparam int AFB_WORD_W = 8;
  localparam int AFB_WORDS = 4;
  localparam int AFB_QUEUES = AFB_WORD_W * AFB_WORDS;
  localparam int AFB_IDX_W = 2;
  localparam int AFB_ID_LSB = AFB_ADDR_W - AFB_ID_W;
  localparam int AFB_WSEL_LSB = 3;
  localparam logic [AFB_IDX_W-1:0] AFB_FIRST_WORD = 2'h0;
  localparam logic [AFB_IDX_W-1:0] AFB_LAST_WORD = 2'h3;
  localparam logic [AFB_ID_W-1:0] AFB_MASTER_ID = 3'h0;
  localparam int AFB_SYNC_STAGES = 2;

  // ==========================================================================
  // apb register map
  localparam int AFB_PADDR_W = 12;
  localparam logic [AFB_PADDR_W-1:0] AFB_CTRL_OFF = 12'h000;
  localparam logic [AFB_PADDR_W-1:0] AFB_STAT_OFF = 12'h004;
  localparam int AFB_CTRL_MRST_BIT = 0;
  localparam logic AFB_CTRL_MRST_RST = 1'b1;
  localparam int AFB_STAT_POLLED_BIT = 0;
  localparam int AFB_STAT_FALL_THROUGH_SELECT_BIT = 1;
  localparam int AFB_STAT_TOKEN_BIT = 2;
  localparam int AFB_STAT_DRIVE_BIT = 3;
  localparam int AFB_STAT_IDX_LSB = 4;
  localparam int AFB_STAT_ID_LSB = 8;
  localparam int AFB_STAT_MRST_BIT = 12;

  // ==========================================================================
  // types
  typedef struct packed {
    logic polled;
    logic fall_through;
    logic [AFB_ID_W-1:0] id;
  } afb_strap_s;

  localparam int AFB_STRAP_W = $bits(afb_strap_s);

  typedef enum {AFB_WAIT, AFB_HOLD} afb_poll_e;

  // pick one status word out of the queue flag vector
  function automatic logic [AFB_WORD_W-1:0] afb_word(
    input logic [AFB_QUEUES-1:0] st,
    input logic [AFB_IDX_W-1:0] idx
  );
    return st[32'(idx) * AFB_WORD_W +: AFB_WORD_W];
  endfunction

endpackage

/* File: rtl/afb_sync.sv */
`timescale 1ns/10ps
module afb_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] stage1;

  // first stage is read by the second only
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      q_o <= '0;
    end
    else
    begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end

endmodule

/* File: test/afb_partner.sv */
`timescale 1ns/10ps
module afb_partner (
  input wire logic polled_i,
  input wire logic break_i,
  input wire logic strobe_req_i,
  input wire logic token_out_i,
  output logic strobe_o,
  output logic token_in_o
);
  // ==========================================================================
  // host write controller and chain
  assign strobe_o = strobe_req_i & ~polled_i;
  // loopback in polled mode unless cut, tied low in direct mode
  assign token_in_o = polled_i & ~break_i & token_out_i;
endmodule

/* File: test/afb_flag_bus_tb.sv */
`timescale 1ns/10ps
module afb_flag_bus_tb;
  import afb_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AFB_PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, strobe, tok_in, bus_oe, sync, tok_out, ft_mode;
  logic mode = 1'b0;
  logic fall_through_select = 1'b1;
  logic [AFB_ID_W-1:0] dev_id = 3'h5;
  logic strobe_req = 1'b0;
  logic [AFB_ADDR_W-1:0] waddr = '0;
  logic ser_en = 1'b1;
  logic cut = 1'b0;
  logic [AFB_QUEUES-1:0] status = '0;
  logic [AFB_WORD_W-1:0] bus;
  logic [33:0] rd_q[$];
  logic [10:0] fb_q[$];
  logic [15:0] lfsr = 16'h10e9;
  int err_total = 0;
  int tests_run = 0;

  afb_flag_bus u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flag_bus_mode_select_i(mode), .fall_through_select_i(fall_through_select),
    .device_identity_inputs_i(dev_id), .almost_full_bus_strobe_i(strobe),
    .write_queue_address_i(waddr), .serial_enable_output_i(ser_en),
    .almost_full_token_in_i(tok_in), .queue_status_i(status),
    .almost_full_flag_bus_o(bus), .almost_full_flag_bus_oe_o(bus_oe),
    .almost_full_bus_sync_o(sync), .almost_full_token_out_o(tok_out),
    .fall_through_mode_o(ft_mode));

  afb_partner u_far (.polled_i(mode), .break_i(cut), .strobe_req_i(strobe_req),
    .token_out_i(tok_out), .strobe_o(strobe), .token_in_o(tok_in));

  initial
  begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================================
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [10:0] fbx(input int k, input logic oe, sync_v, tok_v);
    return {status[8*k+:8], oe, sync_v, tok_v};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // exp: read flag, pslverr, read data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] exp);
    int n;
    n = 0;
    rd_q.push_back(exp);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (fb_q.size() > 0 && n < 50)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    if (fb_q.size() > 0)
    begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic sel(input logic [AFB_ADDR_W-1:0] a, input logic [10:0] exp);
    @(posedge ref_clk_i);
    strobe_req <= 1'b1;
    waddr <= a;
    @(posedge ref_clk_i);
    strobe_req <= 1'b0;
    fb_q.push_back(exp);
    drain();
  endtask

  // ==========================================================================
  // monitor
  always @(negedge ref_clk_i)
  begin : mon
    logic [33:0] e;
    logic [10:0] f;
    if (pready === 1'b1 && rd_q.size() > 0)
    begin
      e = rd_q.pop_front();
      chk("pslverr", {33'h0, e[32]}, {33'h0, pslverr});
      if (e[33])
        chk("prdata", {2'b0, e[31:0]}, {2'b0, prdata});
    end
    if (fb_q.size() > 0)
    begin
      f = fb_q.pop_front();
      // bus value is only meaningful while driven
      chk("flag bus", {23'h0, f}, {23'h0, f[2] ? bus : f[10:3], bus_oe, sync, tok_out});
    end
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    status <= {lfsr, lfsr_next(lfsr)};
    apb(1'b0, AFB_CTRL_OFF, '0, {2'b10, 32'h1});
    repeat (6) @(posedge ref_clk_i);
    apb(1'b1, AFB_CTRL_OFF, 32'h0, 34'h0);
    chk("fall_through", 34'h1, {33'h0, ft_mode});
    apb(1'b0, AFB_STAT_OFF, '0, {2'b10, 32'h502});
    apb(1'b0, 12'h008, '0, {2'b11, 32'h0});
    apb(1'b1, AFB_STAT_OFF, 32'hffff_ffff, 34'h0);
    ser_en <= 1'b0;
    for (int k = 0; k < 4; k++)
      sel({3'h5, 2'(k), lfsr[k+:3]}, fbx(k, 1'b1, 1'b0, 1'b0));
    ser_en <= 1'b1;
    sel({3'h5, 5'h0}, fbx(3, 1'b1, 1'b0, 1'b0));
    ser_en <= 1'b0;
    sel({3'h4, 5'h0}, fbx(3, 1'b0, 1'b0, 1'b0));
    apb(1'b1, AFB_CTRL_OFF, 32'h1, 34'h0);
    mode <= 1'b1;
    fall_through_select <= 1'b0;
    dev_id <= AFB_MASTER_ID;
    lfsr = lfsr_next(lfsr_next(lfsr));
    status <= {lfsr_next(lfsr), lfsr};
    repeat (6) @(posedge ref_clk_i);
    apb(1'b1, AFB_CTRL_OFF, 32'h0, 34'h0);
    @(posedge ref_clk_i);
    for (int i = 0; i < 9; i++)
      fb_q.push_back(fbx(i % 4, 1'b1, i % 4 == 0, i % 4 == 3));
    drain();
    cut <= 1'b1;
    for (int i = 1; i < 6; i++)
      fb_q.push_back(fbx(i > 3 ? 3 : i, i < 4, 1'b0, i == 3));
    drain();
    // idle polled device: only the polled strap bit set
    apb(1'b0, AFB_STAT_OFF, '0, {2'b10, 32'h1});
    chk("fall_through", 34'h0, {33'h0, ft_mode});
    report_and_stop();
  end
endmodule
